// [rtl/ccpu_pkg.sv]
package ccpu_pkg;
   // Register byte addresses on the AXI4-Lite slave; each register takes one aligned word.
   localparam logic [5:0] ADDR_INTCTL  = 6'h00;
   localparam logic [5:0] ADDR_T8CTL   = 6'h04;
   localparam logic [5:0] ADDR_PIE     = 6'h08;
   localparam logic [5:0] ADDR_PIR     = 6'h0C;
   localparam logic [5:0] ADDR_UCTL    = 6'h10;
   localparam logic [5:0] ADDR_CAPLO   = 6'h14;
   localparam logic [5:0] ADDR_CAPHI   = 6'h18;
   localparam logic [5:0] ADDR_CMPLO   = 6'h1C;
   localparam logic [5:0] ADDR_CMPHI   = 6'h20;
   localparam logic [5:0] ADDR_T8PER   = 6'h24;
   localparam logic [5:0] ADDR_T8CNT   = 6'h28;

   // Field positions.
   localparam int GIE_BIT    = 7;
   localparam int PERIPHERAL_IRQ_ENABLE_BIT_BIT   = 6;
   localparam int UNIT_BIT   = 2;
   localparam int T8_BIT     = 1;
   localparam int T8ON_BIT   = 2;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   localparam logic [3:0] MODE_OFF     = 4'h0;
   localparam logic [3:0] MODE_TOGGLE  = 4'h2;
   localparam logic [3:0] MODE_CAP_FALL = 4'h4;
   localparam logic [3:0] MODE_CAP_RISE = 4'h5;
   localparam logic [3:0] MODE_CAP_4    = 4'h6;
   localparam logic [3:0] MODE_CAP_16   = 4'h7;
   localparam logic [3:0] MODE_SET     = 4'h8;
   localparam logic [3:0] MODE_CLR     = 4'h9;
   localparam logic [3:0] MODE_SWI     = 4'hA;
   localparam logic [3:0] MODE_SPECIAL = 4'hB;

   localparam logic [3:0] CAP_DIV4_LAST  = 4'h3;
   localparam logic [3:0] CAP_DIV16_LAST = 4'hF;
   localparam logic [3:0] PRE_DIV1_LAST  = 4'h0;
   localparam logic [3:0] PRE_DIV4_LAST  = 4'h3;
   localparam logic [3:0] PRE_DIV16_LAST = 4'hF;
   localparam logic [7:0] T8PER_RESET    = 8'hFF;
endpackage

// [rtl/ccpu_timer8.sv]
`timescale 1ns/1ns
// 8-bit PWM time base with prescaler, period match and postscaler.
module ccpu_timer8
   import ccpu_pkg::*;
(
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       timer8_on,
   input  wire logic [1:0] timer8_prescale_sel,
   input  wire logic [3:0] timer8_postscale_sel,
   input  wire logic [7:0] period,
   output logic [7:0]      count,
   output logic [1:0]      prescale_phase,
   output logic            period_match,
   output logic            post_event
);
   logic [3:0] pre_r;
   logic [3:0] post_r;
   logic [3:0] pre_last;
   logic       tick;

   always_comb begin
      unique case (timer8_prescale_sel)
         2'b00:   pre_last = PRE_DIV1_LAST;
         2'b01:   pre_last = PRE_DIV4_LAST;
         default: pre_last = PRE_DIV16_LAST;
      endcase
   end

   assign tick           = timer8_on && (pre_r >= pre_last);
   assign period_match   = tick && (count == period);
   assign post_event     = period_match && (post_r == timer8_postscale_sel);
   assign prescale_phase = pre_r[1:0];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pre_r <= 4'h0;
      end else if (timer8_on) begin
         pre_r <= tick ? 4'h0 : pre_r + 4'h1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count <= 8'h00;
      end else if (tick) begin
         count <= period_match ? 8'h00 : count + 8'h01;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         post_r <= 4'h0;
      end else if (period_match) begin
         post_r <= (post_r == timer8_postscale_sel) ? 4'h0 : post_r + 4'h1;
      end
   end

   AST_T8_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
      !timer8_on |=> $stable(count)) else $error("Timer counted while off.");
   AST_POST_ONE: assert property (@(posedge aclk) disable iff (!aresetn)
      period_match && timer8_postscale_sel == 4'h0 |-> post_event)
      else $error("Postscale 1:1 missed an event.");
endmodule // ccpu_timer8

// [rtl/ccpu_unit.sv]
`timescale 1ns/1ns
// How it works
// - Mode zero drives the pin low and clears the capture edge count and latched duty.
// - Capture on falling, rising, every fourth or sixteenth rising pin edge.
// - Toggle mode inverts the pin on compare match and sets the flag.
// - Set mode drives the pin high on match and sets the flag.
// - Clear mode drives the pin low on match and sets the flag.
// - Software interrupt mode only sets the flag on match.
// - Special trigger sets flag, resets the timer, starts conversion if enabled.
// - Modes 11xx run PWM with a ten-bit duty from capture low register and low bits.
// - Duty low bits are stored but unused in capture and compare.
// - Each capture copies the full sixteen-bit timer into the capture pair.
// - Capture sets the flag; only software clears it.
// - A newer capture overwrites an unread older value.
// - Global enable gates every interrupt request.
// - Peripheral enable gates all peripheral interrupt requests.
// - Flags set on their condition regardless of enables.
// - Capture edge prescale counter clears when off, not capturing, or reset.
module ccpu_unit
   import ccpu_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [5:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [5:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [15:0] capture_timer16,
   output logic             timer16_reset,
   input  wire logic        adc_enabled,
   output logic             adc_start,
   input  wire logic        unit_pin_in,
   output logic             unit_pin_out,
   output logic             irq
);
   logic [7:0]  intctl_r, t8ctl_r, pie_r, pir_r, uctl_r;
   logic [7:0]  caplo_r, caphi_r, cmplo_r, cmphi_r, t8per_r;
   logic [7:0]  t8_count;
   logic [1:0]  t8_phase;
   logic        t8_match, t8_post;
   logic [5:0]  awaddr_r;
   logic [31:0] wdata_r;
   logic        aw_have_r, w_have_r;
   logic        wr_fire;
   logic        pin_s1_r, pin_s2_r, pin_prev_r;
   logic        rise, fall, cap_edge, cap_event, cmp_match;
   logic [3:0]  cap_cnt_r;
   logic [3:0]  mode;
   logic        is_capture, is_compare, is_pwm;
   logic [9:0]  duty, pwm_cnt;
   logic [9:0]  duty_latch_r;
   logic        unit_set;
   logic [7:0]  pir_wr;

   assign mode       = uctl_r[3:0];
   assign is_capture = (mode[3:2] == 2'b01);
   assign is_pwm     = (mode[3:2] == 2'b11);
   assign is_compare = (mode == MODE_TOGGLE) || (mode[3:2] == 2'b10);

   // Write channel: address and data are taken in either order, response follows both.
   assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
   assign s_axi_wready  = !w_have_r && !s_axi_bvalid;
   assign wr_fire       = aw_have_r && w_have_r && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r <= 1'b0;
         w_have_r  <= 1'b0;
         awaddr_r  <= 6'h00;
         wdata_r   <= 32'h0000_0000;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_have_r <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            wdata_r  <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0000_0000;
         end else if (wr_fire) begin
            w_have_r <= 1'b0;
         end
      end
   end

   // Only byte lane 0 carries register data; a write with lane 0 off stores nothing.
   logic wr_en0_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_en0_r <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         wr_en0_r <= s_axi_wstrb[0];
      end
   end

   logic wr_map;
   always_comb begin
      unique case (awaddr_r)
         ADDR_INTCTL, ADDR_T8CTL, ADDR_PIE, ADDR_PIR, ADDR_UCTL, ADDR_CAPLO,
         ADDR_CAPHI, ADDR_CMPLO, ADDR_CMPHI, ADDR_T8PER, ADDR_T8CNT: wr_map = 1'b1;
         default: wr_map = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   logic wr_go;
   assign wr_go = wr_fire && wr_en0_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         intctl_r <= 8'h00;
         t8ctl_r  <= 8'h00;
         pie_r    <= 8'h00;
         uctl_r   <= 8'h00;
         cmplo_r  <= 8'h00;
         cmphi_r  <= 8'h00;
         t8per_r  <= T8PER_RESET;
      end else if (wr_go) begin
         if (awaddr_r == ADDR_INTCTL) intctl_r <= wdata_r[7:0];
         if (awaddr_r == ADDR_T8CTL)  t8ctl_r  <= {1'b0, wdata_r[6:0]};
         if (awaddr_r == ADDR_PIE)    pie_r    <= wdata_r[7:0];
         if (awaddr_r == ADDR_UCTL)   uctl_r   <= {2'b00, wdata_r[5:0]};
         if (awaddr_r == ADDR_CMPLO)  cmplo_r  <= wdata_r[7:0];
         if (awaddr_r == ADDR_CMPHI)  cmphi_r  <= wdata_r[7:0];
         if (awaddr_r == ADDR_T8PER)  t8per_r  <= wdata_r[7:0];
      end
   end

   // Read channel.
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= RESP_OKAY;
         unique case (s_axi_araddr)
            ADDR_INTCTL: s_axi_rdata <= {24'h00_0000, intctl_r};
            ADDR_T8CTL:  s_axi_rdata <= {24'h00_0000, t8ctl_r};
            ADDR_PIE:    s_axi_rdata <= {24'h00_0000, pie_r};
            ADDR_PIR:    s_axi_rdata <= {24'h00_0000, pir_r};
            ADDR_UCTL:   s_axi_rdata <= {24'h00_0000, uctl_r};
            ADDR_CAPLO:  s_axi_rdata <= {24'h00_0000, caplo_r};
            ADDR_CAPHI:  s_axi_rdata <= {24'h00_0000, caphi_r};
            ADDR_CMPLO:  s_axi_rdata <= {24'h00_0000, cmplo_r};
            ADDR_CMPHI:  s_axi_rdata <= {24'h00_0000, cmphi_r};
            ADDR_T8PER:  s_axi_rdata <= {24'h00_0000, t8per_r};
            ADDR_T8CNT:  s_axi_rdata <= {24'h00_0000, t8_count};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Pin synchroniser; only the second stage and its delayed copy feed edge logic.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_s1_r   <= 1'b0;
         pin_s2_r   <= 1'b0;
         pin_prev_r <= 1'b0;
      end else begin
         pin_s1_r   <= unit_pin_in;
         pin_s2_r   <= pin_s1_r;
         pin_prev_r <= pin_s2_r;
      end
   end
   assign rise = pin_s2_r && !pin_prev_r;
   assign fall = !pin_s2_r && pin_prev_r;

   assign cap_edge = (mode == MODE_CAP_FALL) ? fall : (is_capture && rise);
   always_ff @(posedge aclk) begin
      if (!aresetn || !is_capture) begin
         cap_cnt_r <= 4'h0;
      end else if (cap_edge) begin
         cap_cnt_r <= cap_cnt_r + 4'h1;
      end
   end
   always_comb begin
      unique case (mode)
         MODE_CAP_FALL, MODE_CAP_RISE: cap_event = cap_edge;
         MODE_CAP_4:  cap_event = cap_edge && (cap_cnt_r[1:0] == CAP_DIV4_LAST[1:0]);
         MODE_CAP_16: cap_event = cap_edge && (cap_cnt_r == CAP_DIV16_LAST);
         default:     cap_event = 1'b0;
      endcase
   end

   // Capture pair; the low byte doubles as the PWM duty high byte.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         caplo_r <= 8'h00;
         caphi_r <= 8'h00;
      end else if (cap_event) begin
         caplo_r <= capture_timer16[7:0];
         caphi_r <= capture_timer16[15:8];
      end else if (wr_go && awaddr_r == ADDR_CAPLO) begin
         caplo_r <= wdata_r[7:0];
      end else if (wr_go && awaddr_r == ADDR_CAPHI) begin
         caphi_r <= wdata_r[7:0];
      end
   end

   assign cmp_match = is_compare && (capture_timer16 == {cmphi_r, cmplo_r});
   assign unit_set  = cap_event || cmp_match;

   // Flags: a hardware set wins over a software clear in the same cycle.
   assign pir_wr = (wr_go && awaddr_r == ADDR_PIR) ? wdata_r[7:0] : pir_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pir_r <= 8'h00;
      end else begin
         pir_r              <= pir_wr;
         pir_r[UNIT_BIT]    <= pir_wr[UNIT_BIT] | unit_set;
         pir_r[T8_BIT]      <= pir_wr[T8_BIT] | t8_post;
      end
   end

   assign irq = intctl_r[GIE_BIT] && intctl_r[PERIPHERAL_IRQ_ENABLE_BIT_BIT] && |(pir_r & pie_r);

   assign timer16_reset = cmp_match && (mode == MODE_SPECIAL);
   assign adc_start     = timer16_reset && adc_enabled;

   // PWM: ten-bit counter is the 8-bit timer plus two prescaler bits; duty latched per period.
   assign duty    = {caplo_r, uctl_r[5:4]};
   assign pwm_cnt = {t8_count, t8_phase};
   always_ff @(posedge aclk) begin
      if (!aresetn || !is_pwm) begin
         duty_latch_r <= 10'h000;
      end else if (t8_match) begin
         duty_latch_r <= duty;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || mode == MODE_OFF) begin
         unit_pin_out <= 1'b0;
      end else if (is_pwm) begin
         unit_pin_out <= (pwm_cnt < duty_latch_r);
      end else if (cmp_match) begin
         unique case (mode)
            MODE_TOGGLE: unit_pin_out <= !unit_pin_out;
            MODE_SET:    unit_pin_out <= 1'b1;
            MODE_CLR:    unit_pin_out <= 1'b0;
            default:     unit_pin_out <= unit_pin_out;
         endcase
      end
   end

   ccpu_timer8 u_timer8 (
      .aclk                 (aclk),
      .aresetn              (aresetn),
      .timer8_on            (t8ctl_r[T8ON_BIT]),
      .timer8_prescale_sel  (t8ctl_r[1:0]),
      .timer8_postscale_sel (t8ctl_r[6:3]),
      .period               (t8per_r),
      .count                (t8_count),
      .prescale_phase       (t8_phase),
      .period_match         (t8_match),
      .post_event           (t8_post)
   );

   sequence s_cap;
      cap_event;
   endsequence
   AST_CAP_COPY: assert property (@(posedge aclk) disable iff (!aresetn)
      s_cap |=> {caphi_r, caplo_r} == $past(capture_timer16)) else $error("Capture lost.");
   AST_FLAG_SET: assert property (@(posedge aclk) disable iff (!aresetn)
      unit_set |=> pir_r[UNIT_BIT]) else $error("Unit flag not set.");
   AST_FLAG_STICKY: assert property (@(posedge aclk) disable iff (!aresetn)
      pir_r[UNIT_BIT] && !(wr_go && awaddr_r == ADDR_PIR) |=> pir_r[UNIT_BIT]) else $error("Flag dropped.");
   AST_TOGGLE: assert property (@(posedge aclk) disable iff (!aresetn)
      cmp_match && mode == MODE_TOGGLE |=> unit_pin_out != $past(unit_pin_out)) else $error("No toggle.");
   AST_SET: assert property (@(posedge aclk) disable iff (!aresetn)
      cmp_match && mode == MODE_SET |=> unit_pin_out) else $error("Pin not set.");
   AST_CLR: assert property (@(posedge aclk) disable iff (!aresetn)
      cmp_match && mode == MODE_CLR |=> !unit_pin_out) else $error("Pin not cleared.");
   AST_SWI: assert property (@(posedge aclk) disable iff (!aresetn)
      cmp_match && (mode == MODE_SWI || mode == MODE_SPECIAL) |=> $stable(unit_pin_out))
      else $error("Pin moved.");
   AST_SPECIAL: assert property (@(posedge aclk) disable iff (!aresetn)
      timer16_reset |-> mode == MODE_SPECIAL && cmp_match) else $error("Bad timer reset.");
   AST_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
      irq |-> intctl_r[GIE_BIT] && intctl_r[PERIPHERAL_IRQ_ENABLE_BIT_BIT]) else $error("Interrupt leaked.");
   AST_PRE_CLR: assert property (@(posedge aclk) disable iff (!aresetn)
      !is_capture |=> cap_cnt_r == 4'h0) else $error("Prescale count kept.");
endmodule // ccpu_unit

// [sim/ccpu_pin_model.sv]
`timescale 1ns/1ns
// Far side of the unit: the source on the unit pin and the 16-bit capture timer.
module ccpu_pin_model (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        run,
   input  wire logic        load_en,
   input  wire logic [15:0] load_val,
   input  wire logic        timer16_reset,
   output logic [15:0]      capture_timer16,
   output logic             unit_pin_in
);
   // The timer can be frozen so that a capture has one exact expected value.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         capture_timer16 <= 16'h0000;
      end else if (timer16_reset) begin
         capture_timer16 <= 16'h0000;
      end else if (load_en) begin
         capture_timer16 <= load_val;
      end else if (run) begin
         capture_timer16 <= capture_timer16 + 16'h0001;
      end
   end

   initial unit_pin_in = 1'b0;

   // Each pulse is one rising and one falling edge, wide enough for the synchroniser.
   task automatic pulses(input int n);
      repeat (n) begin
         repeat (4) @(posedge aclk);
         unit_pin_in <= 1'b1;
         repeat (4) @(posedge aclk);
         unit_pin_in <= 1'b0;
      end
      repeat (6) @(posedge aclk);
   endtask
endmodule // ccpu_pin_model

// [sim/tb.sv]
`timescale 1ns/1ns
module tb;
   import ccpu_pkg::*;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, run, load_en;
   logic        awready, wready, bvalid, arready, rvalid, adc_enabled, adc_start;
   logic        timer16_reset, unit_pin_in, unit_pin_out, irq;
   logic [5:0]  awaddr, araddr;
   logic [3:0]  wstrb;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp;
   logic [15:0] capture_timer16, load_val;
   int          miscompares, n_tests, n_trig, n_adc, cyc;

   ccpu_unit dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .capture_timer16(capture_timer16), .timer16_reset(timer16_reset), .adc_enabled(adc_enabled),
      .adc_start(adc_start), .unit_pin_in(unit_pin_in), .unit_pin_out(unit_pin_out), .irq(irq));

   ccpu_pin_model src (.aclk(aclk), .aresetn(aresetn), .run(run), .load_en(load_en), .load_val(load_val),
      .timer16_reset(timer16_reset), .capture_timer16(capture_timer16), .unit_pin_in(unit_pin_in));

   always #5 aclk = ~aclk;

   always @(posedge aclk) begin
      n_trig <= n_trig + int'(timer16_reset);
      n_adc  <= n_adc + int'(adc_start);
      cyc    <= cyc + 1;
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic tmo(input string nm);
      miscompares++;
      $display("[ERR] %s expected response seen timeout", nm);
      test_done();
   endtask

   task automatic axi_wr(input logic [5:0] a, input logic [7:0] d);
      int k;
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= {24'h0000_00, d};
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (k = 0; k < 100; k++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) begin
            bready <= 1'b0;
            chk("bresp", 32'(RESP_OKAY), 32'(bresp));
            return;
         end
      end
      tmo("write");
   endtask

   task automatic axi_rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
      int k;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (k = 0; k < 100; k++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) begin
            rready <= 1'b0;
            d = rdata;
            r = rresp;
            return;
         end
      end
      tmo("read");
   endtask

   task automatic rdc(input string nm, input logic [5:0] a, input logic [7:0] e);
      logic [31:0] d;
      logic [1:0]  r;
      axi_rd(a, d, r);
      chk(nm, {24'h0000_00, e}, d);
      chk("rresp", 32'(RESP_OKAY), 32'(r));
   endtask

   task automatic load(input logic [15:0] v);
      @(posedge aclk);
      load_val <= v;
      load_en <= 1'b1;
      @(posedge aclk);
      load_en <= 1'b0;
   endtask

   function automatic int cap_div(input logic [3:0] m);
      return (m == MODE_CAP_4) ? 4 : (m == MODE_CAP_16) ? 16 : 1;
   endfunction

   function automatic int pre_div(input logic [1:0] s);
      return s[1] ? 16 : (s[0] ? 4 : 1);
   endfunction

   function automatic logic pin_after(input logic [3:0] m, input logic p);
      case (m)
         MODE_SET: return 1'b1;
         MODE_CLR: return 1'b0;
         MODE_TOGGLE: return ~p;
         default: return p;
      endcase
   endfunction

   initial begin
      logic [31:0] d;
      logic [1:0]  r;
      logic [15:0] v, cmp;
      logic [3:0]  md [7];
      logic [7:0]  c0, dh;
      logic        p;
      int          m, i, t0, a0, hi;
      aclk = 1'b0;
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, run, load_en} = '0;
      {awaddr, araddr, wdata, load_val} = '0;
      wstrb = 4'hF;
      adc_enabled = 1'b1;
      {miscompares, n_tests, n_trig, n_adc, cyc} = '0;
      // Reserved codes one and three are never written.
      md = '{MODE_SET, MODE_CLR, MODE_SET, MODE_TOGGLE, MODE_TOGGLE, MODE_SWI, MODE_SPECIAL};
      void'($urandom(32'h123d_e6bc));
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rdc("intctl", ADDR_INTCTL, 8'h00);
      rdc("t8ctl", ADDR_T8CTL, 8'h00);
      rdc("pie", ADDR_PIE, 8'h00);
      rdc("pir", ADDR_PIR, 8'h00);
      rdc("uctl", ADDR_UCTL, 8'h00);
      rdc("t8per", ADDR_T8PER, T8PER_RESET);
      axi_rd(6'h2C, d, r);
      chk("unmapped rresp", 32'(RESP_SLVERR), 32'(r));
      chk("unmapped rdata", 32'h0000_0000, d);
      axi_wr(ADDR_UCTL, 8'hF0);
      rdc("uctl duty bits", ADDR_UCTL, 8'h30);
      $display("test registers done");
      for (m = 4; m < 8; m++) begin
         axi_wr(ADDR_UCTL, 8'h00);
         axi_wr(ADDR_PIR, 8'h00);
         load(16'($urandom));
         axi_wr(ADDR_UCTL, {2'b00, 2'($urandom), 4'(m)});
         if (cap_div(4'(m)) > 1) begin
            src.pulses(cap_div(4'(m)) - 1);
            rdc("early capture flag", ADDR_PIR, 8'h00);
         end
         for (i = 0; i < 2; i++) begin
            v = 16'($urandom);
            if (i == 1) begin
               load(~v);
               src.pulses(cap_div(4'(m)));
            end
            axi_wr(ADDR_PIR, 8'h00);
            load(v);
            src.pulses((i == 0) ? 1 : cap_div(4'(m)));
            rdc("capture flag", ADDR_PIR, 8'h04);
            rdc("capture low", ADDR_CAPLO, v[7:0]);
            rdc("capture high", ADDR_CAPHI, v[15:8]);
         end
      end
      axi_wr(ADDR_PIR, 8'h00);
      src.pulses(2);
      axi_wr(ADDR_UCTL, 8'h00);
      axi_wr(ADDR_UCTL, {4'h0, MODE_CAP_4});
      src.pulses(2);
      rdc("count cleared by off", ADDR_PIR, 8'h00);
      src.pulses(2);
      rdc("fourth edge after off", ADDR_PIR, 8'h04);
      $display("test capture done");
      cmp = 16'($urandom_range(32'h0000_FFF0, 32'h0000_0100));
      axi_wr(ADDR_CMPLO, cmp[7:0]);
      axi_wr(ADDR_CMPHI, cmp[15:8]);
      axi_wr(ADDR_UCTL, 8'h00);
      p = 1'b0;
      for (i = 0; i < 7; i++) begin
         axi_wr(ADDR_PIR, 8'h00);
         axi_wr(ADDR_UCTL, {2'b00, 2'($urandom), md[i]});
         load(cmp - 16'h0014);
         chk("pin before match", 32'(p), 32'(unit_pin_out));
         t0 = n_trig;
         a0 = n_adc;
         run <= 1'b1;
         repeat (40) @(posedge aclk);
         run <= 1'b0;
         p = pin_after(md[i], p);
         @(posedge aclk);
         chk("pin after match", 32'(p), 32'(unit_pin_out));
         rdc("compare flag", ADDR_PIR, 8'h04);
         chk("timer reset pulses", 32'(md[i] == MODE_SPECIAL), 32'(n_trig - t0));
         chk("conversion starts", 32'(md[i] == MODE_SPECIAL), 32'(n_adc - a0));
      end
      $display("test compare done");
      for (i = 0; i < 8; i++) begin
         axi_wr(ADDR_INTCTL, {i[2], i[1], 6'h00});
         axi_wr(ADDR_PIE, {5'h00, i[0], 2'b00});
         @(posedge aclk);
         chk("irq gating", 32'(i == 7), 32'(irq));
      end
      axi_wr(ADDR_PIR, 8'h00);
      @(posedge aclk);
      chk("irq after clear", 32'h0000_0000, 32'(irq));
      axi_wr(ADDR_INTCTL, 8'h00);
      axi_wr(ADDR_PIE, 8'h00);
      $display("test interrupts done");
      axi_rd(ADDR_T8CNT, d, r);
      c0 = d[7:0];
      repeat (50) @(posedge aclk);
      rdc("timer8 held", ADDR_T8CNT, c0);
      for (i = 0; i < 4; i++) begin
         axi_wr(ADDR_T8CTL, {5'h00, 1'b1, i[1:0]});
         axi_rd(ADDR_T8CNT, d, r);
         c0 = d[7:0];
         repeat (200) @(posedge aclk);
         axi_rd(ADDR_T8CNT, d, r);
         t0 = int'(8'(d[7:0] - c0)) * pre_div(i[1:0]);
         chk("timer8 rate", 32'h0000_0001, 32'(t0 > 185 && t0 < 215));
      end
      $display("test timer8 done");
      // A divide-by-four prescaler makes one PWM period exactly 1024 clocks.
      axi_wr(ADDR_T8CTL, 8'h05);
      for (i = 0; i < 4; i++) begin
         dh = 8'($urandom_range(240, 16));
         axi_wr(ADDR_CAPLO, dh);
         axi_wr(ADDR_UCTL, {2'b00, i[1:0], 2'b11, i[1:0]});
         repeat (2100) @(posedge aclk);
         hi = 0;
         for (t0 = 0; t0 < 1024; t0++) begin
            @(posedge aclk);
            hi += int'(unit_pin_out);
         end
         chk("pwm high cycles", {22'h00_0000, dh, i[1:0]}, 32'(hi));
      end
      axi_wr(ADDR_UCTL, 8'h00);
      @(posedge aclk);
      chk("pin off", 32'h0000_0000, 32'(unit_pin_out));
      $display("test pwm done");
      // Events are timed rise to rise on irq; the first two waits only line up with the event train.
      axi_wr(ADDR_T8PER, 8'h1F);
      hi = int'($urandom_range(15, 0));
      axi_wr(ADDR_T8CTL, {1'b0, 4'(hi), 3'b100});
      axi_wr(ADDR_INTCTL, 8'hC0);
      axi_wr(ADDR_PIE, 8'h02);
      for (i = 0; i < 3; i++) begin
         axi_wr(ADDR_PIR, 8'h00);
         for (t0 = 0; t0 < 600 && irq !== 1'b1; t0++) begin
            @(posedge aclk);
         end
         if (t0 == 600) tmo("postscale");
         if (i == 2) chk("postscale interval", 32'((hi + 1) * 32), 32'(cyc - a0));
         a0 = cyc;
      end
      $display("test postscale done");
      test_done();
   end
endmodule // tb
